// *** rtl/sbrg_top.sv ***
// module: serial rate generator with its registers on an APB slave
`timescale 1ns/100ps
module sbrg_top (
    input wire logic clock,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [sbrg_pkg::ADDR_W-1:0] paddr,
    input wire logic [sbrg_pkg::DATA_W-1:0] pwdata,
    output logic pready,
    output logic [sbrg_pkg::DATA_W-1:0] prdata,
    output logic pslverr,
    input wire logic receive_idle_flag,
    input wire logic transmit_empty,
    input wire logic [2:0] receive_errors,
    output logic rate_tick,
    output logic [7:0] baud_control_out,
    output logic [7:0] receive_status_control_out,
    output logic [7:0] transmit_status_control_out
);

    // ======================================================================
    // bus handshake states
    typedef enum logic [1:0] {
        st_idle = 2'b01,
        st_access = 2'b10
    } sbrg_state_t;

    // ======================================================================
    // address decode, one-hot over the five registers, zero when unmapped
    function automatic logic [4:0] reg_select(logic [sbrg_pkg::ADDR_W-1:0] a);
        logic [4:0] sel;
        sel = 5'h00;
        unique case (a)
            sbrg_pkg::OFF_BAUD_CONTROL: begin
                sel = 5'h01;
            end
            sbrg_pkg::OFF_RECEIVE_STATUS_CONTROL: begin
                sel = 5'h02;
            end
            sbrg_pkg::OFF_RATE_DIVISOR_LOW: begin
                sel = 5'h04;
            end
            sbrg_pkg::OFF_RATE_DIVISOR_HIGH: begin
                sel = 5'h08;
            end
            sbrg_pkg::OFF_TRANSMIT_STATUS_CONTROL: begin
                sel = 5'h10;
            end
            default: begin
                sel = 5'h00; // misaligned or unused address
            end
        endcase
        return sel;
    endfunction

    // ======================================================================
    // register and bus state
    sbrg_state_t state_reg, state_next;
    logic pready_next, pslverr_next;
    logic [sbrg_pkg::DATA_W-1:0] prdata_next;
    logic [7:0] bcon_reg, bcon_next;
    logic [7:0] rsc_reg, rsc_next;
    logic [7:0] tsc_reg, tsc_next;
    logic [7:0] div_lo_reg, div_lo_next;
    logic [7:0] div_hi_reg, div_hi_next;

    // ======================================================================
    // derived controls
    logic [4:0] sel;
    logic setup, commit, wr_commit, timer_restart;
    logic [7:0] rd_byte;
    sbrg_pkg::sbrg_mode_t mode;
    logic [15:0] divisor;

    // decode and the values that software reads back
    always_comb begin
        sel = reg_select(paddr);
        setup = psel && !penable;
        commit = psel && penable && pready && (state_reg == st_access);
        wr_commit = commit && pwrite && (sel != 5'h00);
        // status bits are live inputs; only writable bits are stored
        unique case (sel)
            5'h01: begin
                rd_byte = bcon_reg;
                rd_byte[sbrg_pkg::BIT_RECEIVE_IDLE] = receive_idle_flag;
            end
            5'h02: begin
                rd_byte = rsc_reg | {5'h00, receive_errors};
            end
            5'h04: begin
                rd_byte = div_lo_reg;
            end
            5'h08: begin
                rd_byte = div_hi_reg;
            end
            5'h10: begin
                rd_byte = tsc_reg;
                rd_byte[sbrg_pkg::BIT_TRANSMIT_EMPTY] = transmit_empty;
            end
            default: begin
                rd_byte = 8'h00; // unmapped reads give zero with an error
            end
        endcase
    end

    // mode and divisor gathered for the timer
    always_comb begin
        mode.sync = tsc_reg[sbrg_pkg::BIT_SYNC_MODE];
        mode.high = tsc_reg[sbrg_pkg::BIT_HIGH_SPEED];
        mode.wide = bcon_reg[sbrg_pkg::BIT_WIDE_COUNTER];
        divisor = {div_hi_reg, div_lo_reg};
        // any write to either divisor byte restarts the count
        timer_restart = wr_commit && (sel[2] || sel[3]);
    end

    // ======================================================================
    // bus handshake: answer is prepared in the setup cycle so that pready,
    // prdata and pslverr all leave flip-flops; costs no wait state
    always_comb begin
        state_next = state_reg;
        pready_next = 1'b0;
        pslverr_next = 1'b0;
        prdata_next = prdata;
        unique case (state_reg)
            st_idle: begin
                if (setup) begin
                    state_next = st_access;
                    pready_next = 1'b1;
                    pslverr_next = (sel == 5'h00);
                    prdata_next = pwrite ? '0 : {24'h000000, rd_byte};
                end
            end
            st_access: begin
                // leave on completion, or if the master withdrew psel
                if (commit || !psel) begin
                    state_next = st_idle;
                end else begin
                    pready_next = 1'b1;
                    pslverr_next = pslverr;
                end
            end
        endcase
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_reg <= st_idle;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            state_reg <= state_next;
            pready <= pready_next;
            pslverr <= pslverr_next;
            prdata <= prdata_next;
        end
    end

    // ======================================================================
    // register writes take effect only at the completing edge
    always_comb begin
        bcon_next = bcon_reg;
        rsc_next = rsc_reg;
        tsc_next = tsc_reg;
        div_lo_next = div_lo_reg;
        div_hi_next = div_hi_reg;
        if (wr_commit) begin
            if (sel[0]) begin
                bcon_next = pwdata[7:0] & sbrg_pkg::WMASK_BAUD_CONTROL;
            end
            if (sel[1]) begin
                rsc_next = pwdata[7:0] & sbrg_pkg::WMASK_RECEIVE_STATUS;
            end
            if (sel[2]) begin
                div_lo_next = pwdata[7:0];
            end
            if (sel[3]) begin
                div_hi_next = pwdata[7:0];
            end
            if (sel[4]) begin
                tsc_next = pwdata[7:0] & sbrg_pkg::WMASK_TRANSMIT_STATUS;
            end
        end
    end

    // wide select clears at reset, so the timer starts as an 8-bit counter
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            bcon_reg <= sbrg_pkg::RST_BAUD_CONTROL;
            rsc_reg <= sbrg_pkg::RST_RECEIVE_STATUS_CONTROL;
            tsc_reg <= sbrg_pkg::RST_TRANSMIT_STATUS_CONTROL;
            div_lo_reg <= sbrg_pkg::RST_RATE_DIVISOR;
            div_hi_reg <= sbrg_pkg::RST_RATE_DIVISOR;
        end else begin
            bcon_reg <= bcon_next;
            rsc_reg <= rsc_next;
            tsc_reg <= tsc_next;
            div_lo_reg <= div_lo_next;
            div_hi_reg <= div_hi_next;
        end
    end

    // mode bits go out to transmitter and receiver straight from registers
    always_comb begin
        baud_control_out = bcon_reg;
        receive_status_control_out = rsc_reg;
        transmit_status_control_out = tsc_reg;
    end

    // ======================================================================
    // one timer serves both synchronous and asynchronous operation
    sbrg_rate_timer #(
        .CNT_W(16),
        .PRE_W(6)
    ) u_timer (
        .clock(clock),
        .resetn(resetn),
        .mode(mode),
        .divisor(divisor),
        .restart(timer_restart),
        .rate_tick(rate_tick)
    );

    // ======================================================================
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    sequence s_setup;
        psel && !penable && (state_reg == st_idle);
    endsequence

    sequence s_div_write;
        commit && pwrite && (sel[2] || sel[3]);
    endsequence

    property p_div_write_restart;
        s_div_write |-> timer_restart ##1 !rate_tick [*3];
    endproperty
    a_div_write_restart: assert property (p_div_write_restart) else $error("no restart");

    property p_reserved_zero;
        s_setup ##0 (sel == 5'h01) && !pwrite |=> pready && prdata[5] == 1'b0
            && prdata[2] == 1'b0 && prdata[31:8] == 24'h000000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

    property p_idle_readback;
        s_setup ##0 (sel == 5'h01) && !pwrite
            |=> prdata[6] == $past(receive_idle_flag);
    endproperty
    a_idle_readback: assert property (p_idle_readback) else $error("idle flag lost");

    property p_divisor_pair;
        s_div_write |=> divisor[15:8] == ($past(sel[3]) ? $past(pwdata[7:0])
            : $past(div_hi_reg)) && divisor[7:0] == ($past(sel[2])
            ? $past(pwdata[7:0]) : $past(div_lo_reg));
    endproperty
    a_divisor_pair: assert property (p_divisor_pair) else $error("divisor bytes");

    property p_sync_fast;
        mode.sync |-> sbrg_pkg::prescale_limit(mode) == 6'h03;
    endproperty
    a_sync_fast: assert property (p_sync_fast) else $error("sync multiplier");

    property p_async_slow;
        !mode.sync && !mode.wide && !mode.high
            |-> sbrg_pkg::prescale_limit(mode) == 6'h3F;
    endproperty
    a_async_slow: assert property (p_async_slow) else $error("slow multiplier");

    property p_async_mid;
        !mode.sync && (mode.wide ^ mode.high)
            |-> sbrg_pkg::prescale_limit(mode) == 6'h0F;
    endproperty
    a_async_mid: assert property (p_async_mid) else $error("mid multiplier");

    property p_async_fast;
        !mode.sync && mode.wide && mode.high
            |-> sbrg_pkg::prescale_limit(mode) == 6'h03;
    endproperty
    a_async_fast: assert property (p_async_fast) else $error("fast multiplier");

    property p_setup_answer;
        s_setup |=> pready ##1 !pready;
    endproperty
    a_setup_answer: assert property (p_setup_answer) else $error("answer timing");

endmodule // sbrg_top

// *** rtl/sbrg_pkg.sv ***
// package: constants, types and shared decode for the serial rate generator
// ==========================================================================
// What this block does
// - rate timer is 8 bits after reset, 16 bits while wide select is set
// - one free-running rate timer times both asynchronous and synchronous operation
// - timer period comes from a value n: the divisor register pair at 16 bits, the low divisor byte alone at 8 bits
// - asynchronous multiplier follows high-speed select together with wide select
// - synchronous operation ignores high-speed select
// - async, 8-bit, high-speed clear: clock over 64 times (n+1)
// - async, 16-bit, high-speed clear: clock over 16 times (n+1)
// - synchronous: clock over 4 times (n+1), either counter width
// - n is high divisor byte in bits 15..8, low byte in bits 7..0
// - writing either divisor byte clears the rate timer at once
// - unimplemented baud control bits read as zero
package sbrg_pkg;

    // ======================================================================
    // bus geometry and register offsets (byte addresses, one word each)
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_BAUD_CONTROL = 8'h00;
    localparam logic [7:0] OFF_RECEIVE_STATUS_CONTROL = 8'h04;
    localparam logic [7:0] OFF_RATE_DIVISOR_LOW = 8'h08;
    localparam logic [7:0] OFF_RATE_DIVISOR_HIGH = 8'h0C;
    localparam logic [7:0] OFF_TRANSMIT_STATUS_CONTROL = 8'h10;

    // ======================================================================
    // reset values
    localparam logic [7:0] RST_BAUD_CONTROL = 8'h00;
    localparam logic [7:0] RST_RECEIVE_STATUS_CONTROL = 8'h00;
    localparam logic [7:0] RST_RATE_DIVISOR = 8'h00;
    localparam logic [7:0] RST_TRANSMIT_STATUS_CONTROL = 8'h00;

    // ======================================================================
    // field positions and writable masks
    localparam int BIT_RECEIVE_IDLE = 6;
    localparam int BIT_WIDE_COUNTER = 3;
    localparam int BIT_SYNC_MODE = 4;
    localparam int BIT_HIGH_SPEED = 2;
    localparam int BIT_TRANSMIT_EMPTY = 1;
    localparam logic [7:0] WMASK_BAUD_CONTROL = 8'h9B;
    localparam logic [7:0] WMASK_RECEIVE_STATUS = 8'hF8;
    localparam logic [7:0] WMASK_TRANSMIT_STATUS = 8'hFD;

    // ======================================================================
    // clock cycles per timer step for each mode
    localparam logic [6:0] MULT_SLOW = 7'h40;
    localparam logic [6:0] MULT_MID = 7'h10;
    localparam logic [6:0] MULT_FAST = 7'h04;

    // mode bits that steer the rate timer travel together
    typedef struct packed {
        logic sync;
        logic wide;
        logic high;
    } sbrg_mode_t;

    // last prescaler count of a step: clock cycles per step minus one
    function automatic logic [5:0] prescale_limit(sbrg_mode_t m);
        logic [6:0] mult;
        if (m.sync) begin
            mult = MULT_FAST;
        end else if (m.wide && m.high) begin
            mult = MULT_FAST;
        end else if (m.wide || m.high) begin
            mult = MULT_MID;
        end else begin
            mult = MULT_SLOW;
        end
        return 6'(mult - 7'h01);
    endfunction

endpackage

// *** rtl/sbrg_rate_timer.sv ***
// module: the free-running rate timer with its prescaler
`timescale 1ns/100ps
module sbrg_rate_timer #(
    parameter int CNT_W = 16,
    parameter int PRE_W = 6
) (
    input wire logic clock,
    input wire logic resetn,
    input wire sbrg_pkg::sbrg_mode_t mode,
    input wire logic [CNT_W-1:0] divisor,
    input wire logic restart,
    output logic rate_tick
);
    logic [PRE_W-1:0] pre_reg, pre_next, pre_limit;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic tick_next, step, hit;

    // ======================================================================
    // next state: prescale, count to n, then wrap and tick
    always_comb begin
        pre_limit = PRE_W'(sbrg_pkg::prescale_limit(mode));
        step = (pre_reg >= pre_limit); // >= so a mode change never overruns
        if (mode.wide) begin
            hit = (cnt_reg == divisor);
        end else begin
            hit = (cnt_reg[7:0] == divisor[7:0]);
        end
        pre_next = step ? '0 : pre_reg + 1'b1;
        cnt_next = cnt_reg;
        if (step) begin
            if (hit) begin
                cnt_next = '0;
            end else if (mode.wide) begin
                cnt_next = cnt_reg + 1'b1;
            end else begin
                cnt_next = {{(CNT_W-8){1'b0}}, cnt_reg[7:0] + 8'h01};
            end
        end
        tick_next = step && hit;
        // a divisor write restarts both stages so the new rate starts now
        if (restart) begin
            pre_next = '0;
            cnt_next = '0;
            tick_next = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pre_reg <= '0;
            cnt_reg <= '0;
            rate_tick <= 1'b0;
        end else begin
            pre_reg <= pre_next;
            cnt_reg <= cnt_next;
            rate_tick <= tick_next;
        end
    end

    // ======================================================================
    // checking helpers: cycles since last tick, and whether settings held
    logic [23:0] gap_reg, gap_next, expect_gap;
    logic clean_reg, clean_next;
    sbrg_pkg::sbrg_mode_t mode_d;
    logic [CNT_W-1:0] div_d;
    always_comb begin
        gap_next = rate_tick ? 24'h000001 : gap_reg + 24'h000001;
        clean_next = clean_reg && (mode == mode_d) && (divisor == div_d);
        if (rate_tick) begin
            clean_next = (mode == mode_d) && (divisor == div_d);
        end
        if (restart) begin
            gap_next = 24'h000000;
            clean_next = 1'b1;
        end
        expect_gap = (24'(pre_limit) + 24'h000001)
            * (24'(mode.wide ? divisor : {8'h00, divisor[7:0]}) + 24'h000001);
    end
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            gap_reg <= 24'h000000;
            clean_reg <= 1'b0;
            mode_d <= '0;
            div_d <= '0;
        end else begin
            gap_reg <= gap_next;
            clean_reg <= clean_next;
            mode_d <= mode;
            div_d <= divisor;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    property p_tick_period;
        rate_tick && clean_reg && (mode == mode_d) && (divisor == div_d)
            |-> gap_reg == expect_gap;
    endproperty
    a_tick_period: assert property (p_tick_period) else $error("tick period wrong");

    property p_restart_quiet;
        restart |=> !rate_tick [*4];
    endproperty
    a_restart_quiet: assert property (p_restart_quiet) else $error("tick after restart");

    property p_min_gap;
        rate_tick |=> !rate_tick [*3];
    endproperty
    a_min_gap: assert property (p_min_gap) else $error("ticks too close");

endmodule // sbrg_rate_timer

// *** tb/serial_baud_rate_generator_tb.sv ***
// testbench: register access and rate tick timing of the serial rate generator
`timescale 1ns/100ps
module serial_baud_rate_generator_tb;

    // ======================================================================
    // signals
    logic clock, resetn, psel, penable, pwrite, pready, pslverr;
    logic [sbrg_pkg::ADDR_W-1:0] paddr;
    logic [sbrg_pkg::DATA_W-1:0] pwdata, prdata;
    logic receive_idle_flag, transmit_empty, rate_tick;
    logic [2:0] receive_errors;
    logic [7:0] baud_control_out, receive_status_control_out, transmit_status_control_out;
    integer err_count, total_checks, seed, cycles;
    logic [31:0] rd;
    logic er, s, w, h;
    logic [7:0] lo, hi;
    int n;

    sbrg_top u_dut (
        .clock(clock),
        .resetn(resetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .pready(pready),
        .prdata(prdata),
        .pslverr(pslverr),
        .receive_idle_flag(receive_idle_flag),
        .transmit_empty(transmit_empty),
        .receive_errors(receive_errors),
        .rate_tick(rate_tick),
        .baud_control_out(baud_control_out),
        .receive_status_control_out(receive_status_control_out),
        .transmit_status_control_out(transmit_status_control_out)
    );

    // ======================================================================
    // clock and hang guard
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // a stuck handshake or dead timer must still end in the verdict
    always @(posedge clock) begin
        cycles = cycles + 1;
        if (cycles == 95000) begin
            err_count = err_count + 1;
            tally_and_finish();
        end
    end

    // ======================================================================
    // helpers
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            err_count = err_count + 1;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // bus cycles per clock multiplier, worked out from sync, wide and high-speed bits
    function automatic int rate_mult(input logic sy, input logic wi, input logic hs);
        if (sy) return 4;
        if (wi && hs) return 4;
        if (wi || hs) return 16;
        return 64;
    endfunction

    // one apb transfer; no wait limit of its own, only the bench timeout ends a hang
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int k;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        k = 0;
        // answer is taken at the rising edge that sees pready high, then released
        do begin
            @(posedge clock);
            k++;
        end while (pready !== 1'b1);
        check("pready_wait", 32'(k), 32'h00000001);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rd, er);
    endtask

    task automatic rd_expect(input string name, input logic [7:0] a, input logic [7:0] exp);
        apb(1'b0, a, 32'h0, rd, er);
        check(name, rd, {24'h0, exp});
        check({name, "_err"}, {31'h0, er}, 32'h0);
    endtask

    // counts cycles from the last write to the first tick, then one full period
    task automatic period_check(input string name, input int p, input logic first);
        int k;
        k = 0;
        @(negedge clock);
        while (rate_tick !== 1'b1 && k < 20000) begin
            k++;
            @(negedge clock);
        end
        if (first) check({name, "_first"}, 32'(k), 32'(p));
        k = 0;
        do begin
            @(negedge clock);
            k++;
        end while (rate_tick !== 1'b1 && k < 20000);
        check({name, "_period"}, 32'(k), 32'(p));
    endtask

    // ======================================================================
    // main sequence
    initial begin
        err_count = 0;
        total_checks = 0;
        seed = 61;
        cycles = 0;
        resetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        receive_idle_flag = 1'b0;
        transmit_empty = 1'b0;
        receive_errors = 3'h0;
        repeat (10) @(posedge clock);
        resetn <= 1'b1;
        receive_idle_flag <= 1'($random(seed));
        transmit_empty <= 1'($random(seed));
        receive_errors <= 3'($random(seed));
        // after reset the timer is 8 bits, async, slow: 64 cycles per tick
        period_check("reset_rate", 64, 1'b0);
        rd_expect("baud_rst", sbrg_pkg::OFF_BAUD_CONTROL, {1'b0, receive_idle_flag, 6'h00});
        rd_expect("rx_rst", sbrg_pkg::OFF_RECEIVE_STATUS_CONTROL, {5'h00, receive_errors});
        rd_expect("tx_rst", sbrg_pkg::OFF_TRANSMIT_STATUS_CONTROL, {6'h00, transmit_empty, 1'b0});
        rd_expect("lo_rst", sbrg_pkg::OFF_RATE_DIVISOR_LOW, 8'h00);
        rd_expect("hi_rst", sbrg_pkg::OFF_RATE_DIVISOR_HIGH, 8'h00);
        // all ones: read-only and unimplemented places must not take them
        wr(sbrg_pkg::OFF_BAUD_CONTROL, 32'hFFFFFFFF);
        wr(sbrg_pkg::OFF_TRANSMIT_STATUS_CONTROL, 32'hFFFFFFFF);
        wr(sbrg_pkg::OFF_RECEIVE_STATUS_CONTROL, 32'hFFFFFFFF);
        rd_expect("baud_ones", sbrg_pkg::OFF_BAUD_CONTROL, 8'h9B | {1'b0, receive_idle_flag, 6'h00});
        rd_expect("tx_ones", sbrg_pkg::OFF_TRANSMIT_STATUS_CONTROL, {6'h3F, transmit_empty, 1'b1});
        rd_expect("rx_ones", sbrg_pkg::OFF_RECEIVE_STATUS_CONTROL, {5'h1F, receive_errors});
        check("baud_out", {24'h0, baud_control_out}, 32'h9B);
        check("tx_out", {24'h0, transmit_status_control_out}, 32'hFD);
        check("rx_out", {24'h0, receive_status_control_out}, 32'hF8);
        // unmapped and misaligned places answer with an error and no effect
        apb(1'b0, 8'h20, 32'h0, rd, er);
        check("unmapped_err", {31'h0, er}, 32'h1);
        check("unmapped_data", rd, 32'h0);
        apb(1'b1, 8'h09, 32'h000000AA, rd, er);
        check("misaligned_err", {31'h0, er}, 32'h1);
        rd_expect("lo_untouched", sbrg_pkg::OFF_RATE_DIVISOR_LOW, 8'h00);
        // every mode combination with a random divisor
        for (int m = 0; m < 8; m++) begin
            s = m[2];
            w = m[1];
            h = m[0];
            wr(sbrg_pkg::OFF_BAUD_CONTROL, {28'h0, w, 3'h0});
            wr(sbrg_pkg::OFF_TRANSMIT_STATUS_CONTROL, {27'h0, s, 1'b0, h, 2'h0});
            hi = w ? (8'($random(seed)) & 8'h01) : 8'($random(seed));
            wr(sbrg_pkg::OFF_RATE_DIVISOR_HIGH, {24'h0, hi});
            rd_expect("hi_back", sbrg_pkg::OFF_RATE_DIVISOR_HIGH, hi);
            rd_expect("lo_back_old", sbrg_pkg::OFF_RATE_DIVISOR_LOW, (m == 0) ? 8'h00 : lo);
            lo = 8'($random(seed)) & 8'h1F;
            wr(sbrg_pkg::OFF_RATE_DIVISOR_LOW, {24'h0, lo});
            // eight-bit mode must ignore the high byte entirely
            n = w ? int'({hi, lo}) : int'(lo);
            period_check("mode_rate", rate_mult(s, w, h) * (n + 1), 1'b1);
        end
        // top of the low byte, with a full high byte that must be ignored
        wr(sbrg_pkg::OFF_BAUD_CONTROL, 32'h0);
        wr(sbrg_pkg::OFF_TRANSMIT_STATUS_CONTROL, 32'h00000004);
        wr(sbrg_pkg::OFF_RATE_DIVISOR_HIGH, 32'h000000FF);
        wr(sbrg_pkg::OFF_RATE_DIVISOR_LOW, 32'h000000FF);
        period_check("low_max", 16 * 256, 1'b1);
        // software polls the idle flag before a clock change, so it must track the pin
        @(posedge clock);
        receive_idle_flag <= ~receive_idle_flag;
        @(posedge clock);
        rd_expect("idle_flip", sbrg_pkg::OFF_BAUD_CONTROL, {1'b0, receive_idle_flag, 6'h00});
        // a high-byte write alone restarts the timer mid-count
        wr(sbrg_pkg::OFF_BAUD_CONTROL, 32'h00000008);
        wr(sbrg_pkg::OFF_TRANSMIT_STATUS_CONTROL, 32'h00000010);
        wr(sbrg_pkg::OFF_RATE_DIVISOR_LOW, 32'h00000003);
        repeat (5) @(posedge clock);
        wr(sbrg_pkg::OFF_RATE_DIVISOR_HIGH, 32'h00000000);
        period_check("high_restart", 16, 1'b1);
        tally_and_finish();
    end

endmodule // serial_baud_rate_generator_tb
